//--- tia_pkg.sv
package tia_pkg;
	localparam int CHAN_W = 128;
	localparam int EMPTY_W = 4;
	localparam int CHAN_N = 2;
	localparam int BUF_DEPTH = 2;
	localparam int LVL_W = 2;
	localparam logic [EMPTY_W:0] WORD_BYTES = 5'h10;
	localparam logic [LVL_W-1:0] LVL_FULL = 2'h2;
	localparam logic [LVL_W-1:0] LVL_ZERO = 2'h0;
	localparam logic [LVL_W-1:0] LVL_ONE = 2'h1;
	localparam logic [CHAN_N-1:0] EN_CH0_ONLY = 2'h1;
	localparam logic [CHAN_N-1:0] EN_NONE = 2'h0;

	typedef struct packed {
		logic [CHAN_W-1:0] data;
		logic sop;
		logic eop;
		logic err;
		logic [EMPTY_W-1:0] empty;
	} tia_word_t;

	typedef struct packed {
		tia_word_t word;
		logic [EMPTY_W:0] valid_bytes;
		logic chan;
	} tia_mac_t;

	typedef enum logic [1:0] {
		RR_LAST0 = 2'h1,
		RR_LAST1 = 2'h2
	} tia_rr_t;
endpackage : tia_pkg

//--- tia_pair_buf.sv
module tia_pair_buf
	import tia_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic enable,
	input wire logic in_valid,
	input tia_pkg::tia_word_t in_word,
	output logic in_ready,
	output logic out_valid,
	output tia_pkg::tia_word_t out_word,
	input wire logic out_ready,
	output logic [tia_pkg::LVL_W-1:0] level
);
	tia_word_t mem_q [BUF_DEPTH];
	tia_word_t mem_d [BUF_DEPTH];
	logic wr_q, wr_d, rd_q, rd_d, rdy_q, rdy_d, push, pop;
	logic [LVL_W-1:0] cnt_q, cnt_d;

	assign push = in_valid && rdy_q;
	assign pop = out_valid && out_ready;
	assign out_valid = (cnt_q != LVL_ZERO);
	assign out_word = mem_q[rd_q];
	assign in_ready = rdy_q;
	assign level = cnt_q;

	always_comb
	begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push)
		begin
			mem_d[wr_q] = in_word;
			wr_d = !wr_q;
		end
		if (pop)
			rd_d = !rd_q;
		if (push && !pop)
			cnt_d = cnt_q + LVL_ONE;
		else if (pop && !push)
			cnt_d = cnt_q - LVL_ONE;
		// Drop ready before overflow, raise it again once a slot frees
		rdy_d = enable && (cnt_d != LVL_FULL);
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= LVL_ZERO;
			rdy_q <= 1'b0;
			for (int i = 0; i < BUF_DEPTH; i++)
				mem_q[i] <= '0;
		end
		else if (clk_en)
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
			mem_q <= mem_d;
		end
	end
endmodule : tia_pair_buf

//--- tia_arbiter.sv
module tia_arbiter
	import tia_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [tia_pkg::CHAN_N-1:0] chan_enable,
	input wire logic ch0_word_valid,
	input tia_pkg::tia_word_t ch0_word_bus,
	output logic ch0_accept_ready,
	input wire logic ch1_word_valid,
	input tia_pkg::tia_word_t ch1_word_bus,
	output logic ch1_accept_ready,
	output tia_pkg::tia_mac_t mac_out_q,
	output logic mac_valid_q,
	output logic mac_idle_q,
	input wire logic mac_ready
);
	logic [CHAN_N-1:0] in_valid, in_ready, head_valid, pop;
	tia_word_t in_word [CHAN_N];
	tia_word_t head_word [CHAN_N];
	logic [LVL_W-1:0] lvl [CHAN_N];
	tia_rr_t rr_q, rr_d;
	tia_mac_t out_d;
	logic valid_d, idle_d, load, sel;

	assign in_valid = {ch1_word_valid, ch0_word_valid};
	assign in_word[0] = ch0_word_bus;
	assign in_word[1] = ch1_word_bus;
	assign ch0_accept_ready = in_ready[0];
	assign ch1_accept_ready = in_ready[1];

	// One buffer per channel; both share mclk
	for (genvar c = 0; c < CHAN_N; c++)
	begin : g_chan
		tia_pair_buf u_buf (
			.mclk(mclk),
			.rst_n(rst_n),
			.clk_en(clk_en),
			.enable(chan_enable[c]),
			.in_valid(in_valid[c]),
			.in_word(in_word[c]),
			.in_ready(in_ready[c]),
			.out_valid(head_valid[c]),
			.out_word(head_word[c]),
			.out_ready(pop[c]),
			.level(lvl[c])
		);
	end

	// Output stage frees when empty or drained by the MAC
	assign load = !mac_valid_q || mac_ready;

	always_comb
	begin
		rr_d = rr_q;
		out_d = mac_out_q;
		valid_d = mac_valid_q && !mac_ready;
		idle_d = 1'b0;
		pop = '0;
		sel = 1'b0;
		// Round-robin pick between the two heads
		if (head_valid[0] && head_valid[1])
			sel = (rr_q == RR_LAST0);
		else
			sel = head_valid[1];
		if (load && (|head_valid))
		begin
			pop[sel] = 1'b1;
			out_d.word = head_word[sel];
			out_d.chan = sel;
			// Every word's unused count sets its valid byte total
			out_d.valid_bytes = WORD_BYTES - {1'b0, head_word[sel].empty};
			valid_d = 1'b1;
			rr_d = sel ? RR_LAST1 : RR_LAST0;
		end
		idle_d = !valid_d;
		case (rr_q)
			RR_LAST0, RR_LAST1: ;
			default: rr_d = RR_LAST1;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			rr_q <= RR_LAST1;
			mac_out_q <= '0;
			mac_valid_q <= 1'b0;
			mac_idle_q <= 1'b1;
		end
		else if (clk_en)
		begin
			rr_q <= rr_d;
			mac_out_q <= out_d;
			mac_valid_q <= valid_d;
			mac_idle_q <= idle_d;
		end
	end

	sequence s_both_grant0;
		clk_en && load && head_valid[0] && head_valid[1] && !sel;
	endsequence

	sequence s_both_load;
		clk_en && load && head_valid[0] && head_valid[1];
	endsequence

	sequence s_both_grant1;
		clk_en && load && head_valid[0] && head_valid[1] && sel;
	endsequence

	a_mask_ch1_off: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && chan_enable == EN_CH0_ONLY) |=> !ch1_accept_ready
			&& (lvl[1] <= $past(lvl[1]) || $past(ch1_accept_ready))
	) else $error("channel 1 accepted while masked");

	a_full_no_ready: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(lvl[0] == LVL_FULL) |-> !ch0_accept_ready
	) else $error("ready high with full buffer");

	a_ready_return: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && chan_enable[0] && lvl[0] == LVL_FULL && pop[0] && !ch0_accept_ready)
			|=> ch0_accept_ready
	) else $error("ready not restored after space freed");

	a_idle_gap_fill: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && head_valid == EN_NONE && load) |=> mac_idle_q && !mac_valid_q
	) else $error("no idle fill in gap");

	a_empty_each_word: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && load && head_valid[0] && !head_valid[1] && !head_word[0].eop)
			|=> mac_out_q.valid_bytes == WORD_BYTES - {1'b0, $past(head_word[0].empty)}
	) else $error("unused count ignored mid packet");

	a_accept_counted: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && ch0_word_valid && ch0_accept_ready && !pop[0])
			|=> lvl[0] == $past(lvl[0]) + LVL_ONE
	) else $error("handshake word not taken");

	a_no_take_unready: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && !ch1_accept_ready && !pop[1]) |=> lvl[1] == $past(lvl[1])
	) else $error("word taken without ready");

	a_round_robin: assert property (
		@(posedge mclk) disable iff (!rst_n)
		s_both_grant0 ##1 s_both_load |-> sel
	) else $error("grants did not alternate");

	a_forward_tag: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && load && head_valid[1] && sel)
			|=> mac_valid_q && mac_out_q.chan && mac_out_q.word == $past(head_word[1])
	) else $error("word or tag not forwarded");

	a_stall_holds: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(mac_valid_q && !mac_ready) |=> mac_valid_q && $stable(mac_out_q)
	) else $error("output changed under stall");

	a_reset_quiet: assert property (
		@(posedge mclk)
		!rst_n |=> !ch0_accept_ready && !ch1_accept_ready && !mac_valid_q && mac_idle_q
	) else $error("outputs not quiet after reset");

	a_freeze_hold: assert property (
		@(posedge mclk) disable iff (!rst_n)
		!clk_en |=> $stable(mac_out_q) && $stable(mac_valid_q) && $stable(rr_q)
			&& $stable(lvl[0]) && $stable(lvl[1])
			&& $stable(ch0_accept_ready) && $stable(ch1_accept_ready)
	) else $error("state moved while clock enable low");

	a_disabled_no_ready: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && !chan_enable[0]) |=> !ch0_accept_ready
	) else $error("ready high on disabled channel 0");

	a_full_no_ready1: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(lvl[1] == LVL_FULL) |-> !ch1_accept_ready
	) else $error("channel 1 ready high with full buffer");

	a_ready_return1: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && chan_enable[1] && lvl[1] == LVL_FULL && pop[1] && !ch1_accept_ready)
			|=> ch1_accept_ready
	) else $error("channel 1 ready not restored");

	a_idle_marker: assert property (
		@(posedge mclk) disable iff (!rst_n)
		mac_idle_q != mac_valid_q
	) else $error("idle marker disagrees with valid");

	a_empty_every_out: assert property (
		@(posedge mclk) disable iff (!rst_n)
		mac_valid_q |-> mac_out_q.valid_bytes == WORD_BYTES - {1'b0, mac_out_q.word.empty}
	) else $error("valid byte total wrong");

	a_round_robin1: assert property (
		@(posedge mclk) disable iff (!rst_n)
		s_both_grant1 ##1 s_both_load |-> !sel
	) else $error("grants did not alternate after channel 1");

	a_forward_ch0: assert property (
		@(posedge mclk) disable iff (!rst_n)
		(clk_en && load && head_valid[0] && !sel)
			|=> mac_valid_q && !mac_out_q.chan && mac_out_q.word == $past(head_word[0])
	) else $error("channel 0 word or tag not forwarded");
endmodule : tia_arbiter

//--- tia_src.sv
module tia_src
	import tia_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic go,
	input wire logic [7:0] n_words,
	input wire logic gap,
	input wire logic chan_id,
	input wire logic ready,
	output logic valid,
	output tia_pkg::tia_word_t word,
	output logic [7:0] sent
);
	tia_word_t cur;
	logic tk;
	assign tk = valid && ready;
	always_comb
	begin
		cur = '{data: {chan_id, 119'h0, sent}, sop: sent == 8'h0,
			eop: sent == n_words - 8'h1, err: sent == n_words - 8'h1,
			empty: sent[3:0]};
		word = valid ? cur : ~cur;
	end
	always_ff @(posedge mclk)
	begin
		if (!rst_n || !go)
		begin
			valid <= 1'b0;
			sent <= 8'h0;
		end
		else if (clk_en)
		begin
			sent <= sent + 8'(tk);
			valid <= (sent + 8'(tk) < n_words) && !(gap && tk);
		end
	end
endmodule : tia_src

//--- tx_two_channel_arbiter_intake_test.sv
module tx_two_channel_arbiter_intake_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tia_pkg::*;
	logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, go = 1'b0, gap = 1'b0;
	logic stall = 1'b0, mac_ready = 1'b1, alt = 1'b0, c, last_c, any_out;
	logic [1:0] en = 2'h3;
	logic [7:0] n0 = 8'h0, n1 = 8'h0, s0, s1;
	logic [7:0] rx [2];
	logic v0, v1, r0, r1, mac_valid_q, mac_idle_q;
	logic [159:0] snap;
	tia_word_t w0, w1;
	tia_mac_t mac_out_q;
	int bad_count = 0, n_tests = 0, stalls, idles, cyc = 0;
	logic [27:0] rows [5] = '{{2'h3, 8'h6, 8'h6, 2'h0, 8'h6}, {2'h1, 8'h4, 8'h4, 2'h0, 8'h0},
		{2'h3, 8'h5, 8'h0, 2'h2, 8'h0}, {2'h2, 8'h0, 8'h5, 2'h0, 8'h5},
		{2'h3, 8'h8, 8'h8, 2'h1, 8'h8}};

	initial
		forever #5 mclk = ~mclk;

	tia_arbiter dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .chan_enable(en),
		.ch0_word_valid(v0), .ch0_word_bus(w0), .ch0_accept_ready(r0),
		.ch1_word_valid(v1), .ch1_word_bus(w1), .ch1_accept_ready(r1),
		.mac_out_q(mac_out_q), .mac_valid_q(mac_valid_q), .mac_idle_q(mac_idle_q),
		.mac_ready(mac_ready));
	tia_src src0_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .go(go), .n_words(n0),
		.gap(gap), .chan_id(1'b0), .ready(r0), .valid(v0), .word(w0), .sent(s0));
	tia_src src1_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .go(go), .n_words(n1),
		.gap(gap), .chan_id(1'b1), .ready(r1), .valid(v1), .word(w1), .sent(s1));

	task automatic check(input logic [159:0] got, input logic [159:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	function automatic logic [159:0] exp_word(input logic ch);
		logic [7:0] k;
		k = rx[ch];
		return 160'({ch, 119'h0, k, k == 8'h0, {2{k == (ch ? n1 : n0) - 8'h1}}, k[3:0],
			WORD_BYTES - {1'b0, k[3:0]}});
	endfunction : exp_word

	task automatic conclude();
		$display("counts %0d checks %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		mac_ready <= !stall || cyc % 4 == 0;
		if (!go)
		begin
			rx <= '{8'h0, 8'h0};
			{any_out, stalls, idles} <= '0;
		end
		else if (clk_en)
		begin
			stalls <= stalls + int'(v0 && !r0);
			idles <= idles + int'(mac_idle_q && s0 != 8'h0 && s0 != n0);
			if (mac_valid_q && mac_ready)
			begin
				c = mac_out_q.chan;
				check(160'({mac_out_q.word, mac_out_q.valid_bytes}), exp_word(c));
				if (alt)
					check(160'(c), 160'(any_out && !last_c));
				rx[c] <= rx[c] + 8'h1;
				last_c <= c;
				any_out <= 1'b1;
			end
		end
	end

	task automatic wait_done(input logic [7:0] e1);
		int k;
		for (k = 0; k < 300 && !(rx[0] == n0 && rx[1] == e1); k++)
			@(posedge mclk);
		if (k == 300)
		begin
			bad_count++;
			$display("mismatch at %0t got %h exp %h", $time, {rx[0], rx[1]}, {n0, e1});
		end
		repeat (4) @(posedge mclk);
	endtask : wait_done

	task automatic run(input logic [27:0] r, input logic a);
		go <= 1'b0;
		{en, n0, n1, gap, stall} <= r[27:8];
		alt <= a;
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		wait_done(r[7:0]);
		check(160'({rx[0], rx[1], s1, mac_valid_q}), 160'({n0, r[7:0], r[7:0], 1'b0}));
		if (stall)
			check(160'(stalls > 0), 160'(1));
		if (gap)
			check(160'(idles > 0), 160'(1));
		$display("test done mask %h checks %0d", en, n_tests);
	endtask : run

	initial
	begin
		#100us;
		bad_count++;
		conclude();
	end

	initial
	begin
		repeat (6) @(posedge mclk);
		check(160'({r0, r1, mac_valid_q, mac_idle_q}), 160'(4'h1));
		$display("test done power-up reset checks %0d", n_tests);
		rst_n <= 1'b1;
		foreach (rows[i])
			run(rows[i], i == 0);
		{go, stall, alt} <= 3'h0;
		@(posedge mclk);
		go <= 1'b1;
		repeat (3) @(posedge mclk);
		clk_en <= 1'b0;
		@(posedge mclk);
		#1 snap = 160'({mac_out_q, mac_valid_q, s0});
		repeat (4) @(posedge mclk);
		#1 check(160'({mac_out_q, mac_valid_q, s0}), snap);
		@(posedge mclk);
		clk_en <= 1'b1;
		wait_done(n1);
		check(160'({rx[0], rx[1]}), 160'({n0, n1}));
		$display("test done freeze checks %0d", n_tests);
		go <= 1'b0;
		@(posedge mclk);
		go <= 1'b1;
		repeat (6) @(posedge mclk);
		{rst_n, go} <= 2'h0;
		repeat (2) @(posedge mclk);
		check(160'({r0, r1, mac_valid_q, mac_idle_q}), 160'(4'h1));
		rst_n <= 1'b1;
		@(posedge mclk);
		go <= 1'b1;
		@(posedge mclk);
		wait_done(n1);
		check(160'({rx[0], rx[1], mac_valid_q}), 160'({n0, n1, 1'b0}));
		$display("test done mid-run reset checks %0d", n_tests);
		conclude();
	end
endmodule : tx_two_channel_arbiter_intake_test
